//--- hdl/sfc_pkg.sv
// package: register map, field layouts and fifo sizes of the fifo configuration block
`default_nettype none
package sfc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 3;
  // register byte addresses
  localparam logic [7:0] OFF_FIFO_CFG  = 8'h00;
  localparam logic [7:0] OFF_CHAN_CTRL = 8'h04;
  localparam logic [7:0] OFF_RX_FILL   = 8'h08;
  localparam logic [7:0] OFF_STATE     = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;
  // field positions
  localparam int unsigned CTRL_RXE_BIT = 0;
  localparam int unsigned CTRL_TXE_BIT = 1;
  localparam int unsigned CTRL_DPX_LSB = 2;
  localparam int unsigned CFG_W        = 8;
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned EV_TX_IRQ    = 0;
  localparam int unsigned EV_RX_IRQ    = 1;
  localparam int unsigned EV_RX_OFF    = 2;
  localparam int unsigned EV_TX_OFF    = 3;
  // reset values
  localparam logic [7:0]       CFG_RESET  = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET  = 4'h0;
  localparam logic [1:0]       FILL_RESET = 2'h0;
  // duplex select codes
  localparam logic [1:0] DPX_NONE    = 2'h0;
  localparam logic [1:0] DPX_HALF_RX = 2'h1;
  localparam logic [1:0] DPX_HALF_TX = 2'h2;
  localparam logic [1:0] DPX_FULL    = 2'h3;
  // fifo byte counts
  localparam logic [CNT_W-1:0] BYTES_0 = 3'h0;
  localparam logic [CNT_W-1:0] BYTES_1 = 3'h1;
  localparam logic [CNT_W-1:0] BYTES_2 = 3'h2;
  localparam logic [CNT_W-1:0] BYTES_3 = 3'h3;
  localparam logic [CNT_W-1:0] BYTES_4 = 3'h4;

  typedef struct packed {
    logic [2:0] reserved;
    logic       rx_usage_select;
    logic       tx_fifo_irq_enable;
    logic       rx_fifo_irq_enable;
    logic       auto_disable_enable;
    logic       fifo_enable;
  } sfc_cfg_s;

  typedef struct packed {
    logic [CNT_W-1:0] rx_depth;
    logic [CNT_W-1:0] tx_depth;
    logic [CNT_W-1:0] rx_used;
  } sfc_plan_s;
endpackage
`default_nettype wire

//--- hdl/sfc_fifo_plan.sv
// fifo partition and receive usage, registered from configuration
`default_nettype none
module sfc_fifo_plan
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // configuration
  input  wire sfc_pkg::sfc_cfg_s cfg,
  input  wire logic [1:0]        duplex,
  input  wire logic [1:0]        fill_level,
  // result
  output sfc_pkg::sfc_plan_s     plan_ff
);
  import sfc_pkg::*;

  // receive fill level in bytes, halves of the table differ by duplex
  function automatic logic [CNT_W-1:0] fill_bytes(input logic [1:0] lvl, input logic full);
    logic [CNT_W-1:0] b;
    b = BYTES_0;
    case (lvl)
      2'h0:    b = full ? BYTES_2 : BYTES_4;
      2'h1:    b = BYTES_1;
      2'h2:    b = BYTES_2;
      default: b = full ? BYTES_1 : BYTES_3;
    endcase
    return b;
  endfunction

  sfc_plan_s nxt_plan;

  always_comb
  begin
    nxt_plan = '0;
    if (cfg.fifo_enable)
    begin
      case (duplex)
        DPX_HALF_RX: nxt_plan.rx_depth = BYTES_4;
        DPX_HALF_TX: nxt_plan.tx_depth = BYTES_4;
        DPX_FULL:
        begin
          nxt_plan.rx_depth = BYTES_2;
          nxt_plan.tx_depth = BYTES_2;
        end
        default: nxt_plan = '0;
      endcase
      // tx side ignores the usage select, always its full depth
      if (cfg.rx_usage_select && nxt_plan.rx_depth != BYTES_0)
        nxt_plan.rx_used = fill_bytes(fill_level, duplex == DPX_FULL);
      else
        nxt_plan.rx_used = nxt_plan.rx_depth;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      plan_ff <= '0;
    else
      plan_ff <= nxt_plan;
  end
endmodule // sfc_fifo_plan
`default_nettype wire

//--- hdl/sfc_top.sv
// fifo configuration logic of a serial channel with register port and interrupt
//
// Our own choices: the plain strobed port and the placing of the registers.
`default_nettype none
// Operation
// - usage select clear: rx uses full depth
// - usage select set: rx uses fill level
// - tx fifo irq enable gates tx interrupts
// - rx fifo irq enable gates rx interrupts
// - half rx: auto clear rx enable when full
// - half tx: auto clear tx enable when empty
// - full duplex: either condition clears both enables
// - fifo enable partitions depth from duplex setting
// - tx fifo always offers its full depth
module sfc_top
(
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset_n,
  // register port
  input  wire logic [sfc_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [sfc_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [sfc_pkg::DATA_W-1:0]   reg_rdata_ff,
  // channel status
  input  wire logic                         rx_shift_full,
  input  wire logic                         rx_buf_full,
  input  wire logic [sfc_pkg::CNT_W-1:0]    rx_fifo_count,
  input  wire logic                         tx_shift_empty,
  input  wire logic                         tx_buf_empty,
  input  wire logic [sfc_pkg::CNT_W-1:0]    tx_fifo_count,
  input  wire logic                         tx_irq_req,
  input  wire logic                         rx_irq_req,
  // channel control
  output logic                              rx_enable_ff,
  output logic                              tx_enable_ff,
  output logic                              fifo_enable_ff,
  output sfc_pkg::sfc_plan_s                plan_ff,
  output logic                              tx_irq_ff,
  output logic                              rx_irq_ff,
  // interrupt
  output logic                              irq_ff
);
  import sfc_pkg::*;

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  sfc_cfg_s             cfg_ff;
  logic [1:0]           duplex_ff;
  logic [1:0]           fill_level_ff;
  logic [IRQ_W-1:0]     irq_stat_ff;
  logic [IRQ_W-1:0]     irq_mask_ff;
  logic                 wr_cfg;
  logic                 wr_ctrl;
  logic                 wr_fill;
  logic                 wr_stat;
  logic                 wr_mask;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign wr_cfg  = reg_wr && hit(reg_addr, OFF_FIFO_CFG);
  assign wr_ctrl = reg_wr && hit(reg_addr, OFF_CHAN_CTRL);
  assign wr_fill = reg_wr && hit(reg_addr, OFF_RX_FILL);
  assign wr_stat = reg_wr && hit(reg_addr, OFF_IRQ_STAT);
  assign wr_mask = reg_wr && hit(reg_addr, OFF_IRQ_MASK);

  // reserved bits are stored and read back as written
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      cfg_ff <= CFG_RESET;
    else if (wr_cfg)
      cfg_ff <= reg_wdata[CFG_W-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      duplex_ff     <= DPX_NONE;
      fill_level_ff <= FILL_RESET;
    end
    else
    begin
      if (wr_ctrl)
        duplex_ff <= reg_wdata[CTRL_DPX_LSB +: 2];
      if (wr_fill)
        fill_level_ff <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      fifo_enable_ff <= 1'b0;
    else
      fifo_enable_ff <= cfg_ff.fifo_enable;
  end

  // ------------------------------------------------------------
  // fifo partition
  // ------------------------------------------------------------
  // registered so depth outputs never glitch on a config write
  sfc_fifo_plan u_plan
  (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .cfg        (cfg_ff),
    .duplex     (duplex_ff),
    .fill_level (fill_level_ff),
    .plan_ff    (plan_ff)
  );

  // ------------------------------------------------------------
  // automatic disable of transfer enables
  // ------------------------------------------------------------
  logic auto_on;
  logic rx_full_hit;
  logic tx_empty_hit;
  logic clr_rx;
  logic clr_tx;
  logic nxt_rx_enable;
  logic nxt_tx_enable;

  // option is dead while the fifo is off
  assign auto_on      = cfg_ff.fifo_enable && cfg_ff.auto_disable_enable;
  assign rx_full_hit  = auto_on && rx_shift_full && rx_buf_full
                        && (rx_fifo_count == plan_ff.rx_used);
  assign tx_empty_hit = auto_on && tx_shift_empty && tx_buf_empty
                        && (tx_fifo_count == BYTES_0);

  always_comb
  begin
    clr_rx = 1'b0;
    clr_tx = 1'b0;
    case (duplex_ff)
      DPX_HALF_RX: clr_rx = rx_full_hit;
      DPX_HALF_TX: clr_tx = tx_empty_hit;
      DPX_FULL:
      begin
        clr_rx = rx_full_hit || tx_empty_hit;
        clr_tx = rx_full_hit || tx_empty_hit;
      end
      default:
      begin
        clr_rx = 1'b0;
        clr_tx = 1'b0;
      end
    endcase
  end

  // hardware clear beats a same-cycle software set, else a full line restarts
  always_comb
  begin
    nxt_rx_enable = wr_ctrl ? reg_wdata[CTRL_RXE_BIT] : rx_enable_ff;
    nxt_tx_enable = wr_ctrl ? reg_wdata[CTRL_TXE_BIT] : tx_enable_ff;
    if (clr_rx)
      nxt_rx_enable = 1'b0;
    if (clr_tx)
      nxt_tx_enable = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      rx_enable_ff <= 1'b0;
      tx_enable_ff <= 1'b0;
    end
    else
    begin
      rx_enable_ff <= nxt_rx_enable;
      tx_enable_ff <= nxt_tx_enable;
    end
  end

  // ------------------------------------------------------------
  // fifo interrupt gating
  // ------------------------------------------------------------
  logic nxt_tx_irq;
  logic nxt_rx_irq;

  // with the fifo off the requests pass untouched
  assign nxt_tx_irq = tx_irq_req && (!cfg_ff.fifo_enable || cfg_ff.tx_fifo_irq_enable);
  assign nxt_rx_irq = rx_irq_req && (!cfg_ff.fifo_enable || cfg_ff.rx_fifo_irq_enable);

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end
    else
    begin
      tx_irq_ff <= nxt_tx_irq;
      rx_irq_ff <= nxt_rx_irq;
    end
  end

  // ------------------------------------------------------------
  // interrupt status, mask and output
  // ------------------------------------------------------------
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] nxt_irq_stat;

  always_comb
  begin
    irq_events            = IRQ_RESET;
    irq_events[EV_TX_IRQ] = nxt_tx_irq;
    irq_events[EV_RX_IRQ] = nxt_rx_irq;
    irq_events[EV_RX_OFF] = clr_rx && rx_enable_ff;
    irq_events[EV_TX_OFF] = clr_tx && tx_enable_ff;
  end

  // a new event wins over a same-cycle write-one clear
  assign nxt_irq_stat = (irq_stat_ff & ~(wr_stat ? reg_wdata[IRQ_W-1:0] : IRQ_RESET))
                        | irq_events;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      irq_stat_ff <= IRQ_RESET;
    else
      irq_stat_ff <= nxt_irq_stat;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      irq_mask_ff <= IRQ_RESET;
    else if (wr_mask)
      irq_mask_ff <= reg_wdata[IRQ_W-1:0];
  end

  // one cycle behind the status, keeps the output a plain flop
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  logic [DATA_W-1:0] nxt_rdata;

  always_comb
  begin
    nxt_rdata = '0;
    case (reg_addr)
      OFF_FIFO_CFG:  nxt_rdata[CFG_W-1:0] = cfg_ff;
      OFF_CHAN_CTRL:
      begin
        nxt_rdata[CTRL_RXE_BIT]      = rx_enable_ff;
        nxt_rdata[CTRL_TXE_BIT]      = tx_enable_ff;
        nxt_rdata[CTRL_DPX_LSB +: 2] = duplex_ff;
      end
      OFF_RX_FILL:   nxt_rdata[1:0] = fill_level_ff;
      OFF_STATE:     nxt_rdata[5*CNT_W-1:0] = {tx_fifo_count, rx_fifo_count, plan_ff};
      OFF_IRQ_STAT:  nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
      OFF_IRQ_MASK:  nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
      default:       nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      reg_rdata_ff <= '0;
    else if (reg_rd)
      reg_rdata_ff <= nxt_rdata;
    else
      reg_rdata_ff <= '0;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  cfg_reserved_a: assert property (wr_cfg |=> cfg_ff.reserved == $past(reg_wdata[7:5]))
    else $error("reserved config bits not stored");

  rx_used_max_a: assert property ((cfg_ff.fifo_enable && !cfg_ff.rx_usage_select)
    |=> plan_ff.rx_used == plan_ff.rx_depth)
    else $error("rx usage not at full depth");

  rx_used_fill_a: assert property ((cfg_ff.fifo_enable && cfg_ff.rx_usage_select
    && duplex_ff == DPX_HALF_RX && fill_level_ff == 2'h3) |=> plan_ff.rx_used == BYTES_3)
    else $error("rx usage not equal to fill level");

  tx_irq_gate_a: assert property ((cfg_ff.fifo_enable && !cfg_ff.tx_fifo_irq_enable)
    |=> !tx_irq_ff)
    else $error("tx interrupt passed while disabled");

  rx_irq_pass_a: assert property ((cfg_ff.fifo_enable && cfg_ff.rx_fifo_irq_enable
    && rx_irq_req) |=> rx_irq_ff)
    else $error("rx interrupt lost while enabled");

  rx_auto_off_a: assert property ((rx_full_hit && duplex_ff == DPX_HALF_RX)
    |=> !rx_enable_ff && tx_enable_ff == $past(nxt_tx_enable))
    else $error("rx enable not cleared when full");

  tx_auto_off_a: assert property ((tx_empty_hit && duplex_ff == DPX_HALF_TX)
    |=> !tx_enable_ff)
    else $error("tx enable not cleared when empty");

  full_auto_off_a: assert property ((duplex_ff == DPX_FULL && (rx_full_hit || tx_empty_hit))
    |=> !rx_enable_ff && !tx_enable_ff)
    else $error("full duplex enables not both cleared");

  full_split_a: assert property ((cfg_ff.fifo_enable && duplex_ff == DPX_FULL)
    |=> plan_ff.rx_depth == BYTES_2 && plan_ff.tx_depth == BYTES_2)
    else $error("full duplex partition wrong");

  tx_full_depth_a: assert property ((cfg_ff.fifo_enable && duplex_ff == DPX_HALF_TX)
    |=> plan_ff.tx_depth == BYTES_4 && plan_ff.rx_used == BYTES_0)
    else $error("tx fifo not at full depth");

  fifo_off_a: assert property (!cfg_ff.fifo_enable
    |=> tx_irq_ff == $past(tx_irq_req) && plan_ff == '0 && !$past(clr_rx || clr_tx))
    else $error("fifo options acted while fifo off");

  irq_out_a: assert property (|(irq_stat_ff & irq_mask_ff) |=> irq_ff [*1] ##1 1)
    else $error("interrupt output missed");

  set_wins_a: assert property (|irq_events |=> (irq_stat_ff & $past(irq_events)) == $past(irq_events))
    else $error("event lost against clear");

  full_off_c: cover property (duplex_ff == DPX_FULL && rx_full_hit && tx_enable_ff);
  half_tx_off_c: cover property (duplex_ff == DPX_HALF_TX && tx_empty_hit ##1 irq_ff);
  rx_fill_c: cover property (cfg_ff.rx_usage_select && plan_ff.rx_used == BYTES_1);
  gated_c: cover property (tx_irq_req && cfg_ff.fifo_enable && !cfg_ff.tx_fifo_irq_enable);
endmodule // sfc_top
`default_nettype wire

//--- verif/sfc_chan_model.sv
// channel-side model: fifo fill counts and shift/buffer flags
`default_nettype none
module sfc_chan_model
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // bench commands
  input  wire logic       flush,
  input  wire logic       rx_go,
  input  wire logic       tx_go,
  input  wire logic [2:0] rx_target,
  input  wire logic [2:0] tx_start,
  // enables from the block
  input  wire logic       rx_enable,
  input  wire logic       tx_enable,
  // status to the block
  output logic            rx_shift_full,
  output logic            rx_buf_full,
  output logic [2:0]      rx_fifo_count,
  output logic            tx_shift_empty,
  output logic            tx_buf_empty,
  output logic [2:0]      tx_fifo_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // byte-wide frames only, the fifo never meets 9-bit mode
  logic [2:0] rx_cnt_ff;
  logic [2:0] tx_cnt_ff;
  logic       tx_shift_ff;
  // -------------------------------------------
  // counters
  // -------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || flush)
    begin
      rx_cnt_ff <= 3'h0;
      tx_cnt_ff <= 3'h0;
    end
    else
    begin
      if (rx_go && rx_enable && rx_cnt_ff < rx_target)
        rx_cnt_ff <= rx_cnt_ff + 3'h1;
      // idle transmitter is preloaded so it never looks empty early
      if (!tx_enable)
        tx_cnt_ff <= tx_start;
      else if (tx_go && tx_cnt_ff != 3'h0)
        tx_cnt_ff <= tx_cnt_ff - 3'h1;
    end
  end
  // shift register drains one cycle after the buffer
  always_ff @(posedge core_clk)
    tx_shift_ff <= reset_n && tx_cnt_ff == 3'h0;
  assign rx_buf_full    = rx_target != 3'h0 && rx_cnt_ff == rx_target;
  assign rx_shift_full  = rx_buf_full;
  assign rx_fifo_count  = rx_cnt_ff;
  assign tx_buf_empty   = tx_cnt_ff == 3'h0;
  assign tx_shift_empty = tx_shift_ff && tx_buf_empty;
  assign tx_fifo_count  = tx_cnt_ff;
endmodule // sfc_chan_model
`default_nettype wire

//--- verif/sfc_top_tb_top.sv
// testbench for the fifo configuration block
`default_nettype none
module sfc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sfc_pkg::*;
  logic        core_clk, reset_n, reg_wr, reg_rd, tx_irq_req, rx_irq_req;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff;
  logic        rx_shift_full, rx_buf_full, tx_shift_empty, tx_buf_empty;
  logic [2:0]  rx_fifo_count, tx_fifo_count, rx_target, tx_start;
  logic        rx_enable_ff, tx_enable_ff, fifo_enable_ff, tx_irq_ff, rx_irq_ff, irq_ff;
  logic        flush, rx_go, tx_go;
  sfc_plan_s   plan_ff;
  int          n_mismatch, total_checks, cyc;

  sfc_top sfc_top_inst (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_ff, .rx_shift_full, .rx_buf_full, .rx_fifo_count, .tx_shift_empty,
    .tx_buf_empty, .tx_fifo_count, .tx_irq_req, .rx_irq_req, .rx_enable_ff, .tx_enable_ff,
    .fifo_enable_ff, .plan_ff, .tx_irq_ff, .rx_irq_ff, .irq_ff);
  sfc_chan_model sfc_chan_model_inst (.core_clk, .reset_n, .flush, .rx_go, .tx_go,
    .rx_target, .tx_start, .rx_enable(rx_enable_ff), .tx_enable(tx_enable_ff),
    .rx_shift_full, .rx_buf_full, .rx_fifo_count, .tx_shift_empty, .tx_buf_empty,
    .tx_fifo_count);

  // -------------------------------------------
  // clock, timeout and report
  // -------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // whole run needs well under a thousand cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  // -------------------------------------------
  // access tasks
  // -------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_ff, exp);
  endtask
  function automatic logic [8:0] exp_plan(input int d, input int s, input int f);
    logic [2:0] rx;
    logic [2:0] tx;
    logic [2:0] u;
    rx = d == 1 ? 3'h4 : d == 3 ? 3'h2 : 3'h0;
    tx = d == 2 ? 3'h4 : d == 3 ? 3'h2 : 3'h0;
    if (s == 0)
      u = rx;
    else if (d == 1)
      u = f == 0 ? 3'h4 : 3'(f);
    else
      u = f[0] ? 3'h1 : 3'h2;
    return {rx, tx, u};
  endfunction
  // quiesce, configure, flush, enable, then wait for auto clear and its interrupt
  task automatic auto_case(input logic [7:0] cfg, input logic [3:0] ctrl,
                           input logic [2:0] rt, input logic [2:0] ts,
                           input logic rg, input logic tg, input logic [3:0] stat);
    int n;
    @(posedge core_clk);
    rx_target <= rt;
    tx_start  <= ts;
    rx_go     <= rg;
    tx_go     <= tg;
    // enables off first so a stale full or empty line raises no event
    wr(OFF_CHAN_CTRL, 32'(ctrl & 4'hC));
    wr(OFF_FIFO_CFG, 32'(cfg));
    @(posedge core_clk);
    flush <= 1'b1;
    @(posedge core_clk);
    flush <= 1'b0;
    wr(OFF_IRQ_STAT, 32'hF);
    wr(OFF_CHAN_CTRL, 32'(ctrl));
    #1;
    n = 0;
    while (n < 30 && (rx_enable_ff | tx_enable_ff) === 1'b1)
    begin
      wait_cyc(1);
      n++;
    end
    wait_cyc(2);
    chk({rx_enable_ff, tx_enable_ff}, (cfg[1] && cfg[0]) ? 2'h0 : {ctrl[0], ctrl[1]});
    chk(irq_ff, stat != 4'h0);
    rd(OFF_IRQ_STAT, 32'(stat));
    wr(OFF_IRQ_STAT, 32'(stat));
    wait_cyc(2);
    chk(irq_ff, 1'b0);
  endtask
  // -------------------------------------------
  // test sequence
  // -------------------------------------------
  initial
  begin
    {reset_n, reg_wr, reg_rd, tx_irq_req, rx_irq_req, flush, rx_go, tx_go} = '0;
    {reg_addr, reg_wdata, rx_target, tx_start} = '0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_cyc(1);
    chk({plan_ff, rx_enable_ff, tx_enable_ff, fifo_enable_ff, tx_irq_ff, rx_irq_ff, irq_ff}, 0);
    for (int i = 0; i < 7; i++)
      rd(8'(i * 4), 32'h0);
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, 32'h0);
    wr(OFF_FIFO_CFG, 32'h1F);
    rd(OFF_FIFO_CFG, 32'h1F);
    for (int d = 0; d < 4; d++)
      for (int s = 0; s < 2; s++)
        for (int f = 0; f < 4; f++)
        begin
          if (s == 1 && d % 2 == 0)
            continue;
          wr(OFF_CHAN_CTRL, 32'(d) << CTRL_DPX_LSB);
          wr(OFF_RX_FILL, 32'(f));
          wr(OFF_FIFO_CFG, 32'h01 | 32'(s) << 4);
          wait_cyc(3);
          chk(32'(plan_ff), 32'(exp_plan(d, s, f)));
          chk(fifo_enable_ff, 1'b1);
          rd(OFF_STATE, 32'(exp_plan(d, s, f)));
        end
    wr(OFF_FIFO_CFG, 32'h10);
    wait_cyc(3);
    chk({fifo_enable_ff, plan_ff}, 0);
    for (int f = 0; f < 2; f++)
      for (int e = 0; e < 2; e++)
      begin
        wr(OFF_FIFO_CFG, 32'(f) | 32'(e) << 2 | 32'(e) << 3);
        tx_irq_req <= 1'b1;
        rx_irq_req <= 1'b1;
        wait_cyc(3);
        chk(tx_irq_ff, f == 0 || e == 1);
        chk(rx_irq_ff, f == 0 || e == 1);
        @(posedge core_clk);
        tx_irq_req <= 1'b0;
        rx_irq_req <= 1'b0;
      end
    wr(OFF_IRQ_MASK, 32'hC);
    auto_case(8'h01, 4'h5, 3'h4, 3'h0, 1'b1, 1'b0, 4'h0);
    auto_case(8'h02, 4'h5, 3'h4, 3'h0, 1'b1, 1'b0, 4'h0);
    auto_case(8'h03, 4'h5, 3'h4, 3'h0, 1'b1, 1'b0, 4'h4);
    // fill level register still holds 3 from the partition sweep
    auto_case(8'h13, 4'h5, 3'h3, 3'h0, 1'b1, 1'b0, 4'h4);
    auto_case(8'h03, 4'hA, 3'h0, 3'h3, 1'b0, 1'b1, 4'h8);
    auto_case(8'h03, 4'hF, 3'h2, 3'h3, 1'b1, 1'b0, 4'hC);
    auto_case(8'h03, 4'hF, 3'h0, 3'h1, 1'b0, 1'b1, 4'hC);
    print_verdict();
  end
endmodule // sfc_top_tb_top
`default_nettype wire
